// ---- src/cec_capture.sv ----
/*
  Error and arbitration capture block with its Wishbone register slave.
  Assumes a CAN protocol engine that reports the current frame field, pulses
  one error-type strobe per detected bus error, pulses arbitration loss with
  the bit index inside the field, and pulses successful transmit or receive.
  All inputs are synchronous to clk_i.
*/
// Our own choices: the address map and the Wishbone register port.
module cec_capture
  import cec_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Protocol engine side
  input  wire cec_field_e        field_i,
  input  wire logic              transmitting_i,
  input  wire logic              err_bit_i,
  input  wire logic              err_form_i,
  input  wire logic              err_stuff_i,
  input  wire logic              err_other_i,
  input  wire logic              arb_lost_i,
  input  wire logic [4:0]        arb_bit_i,
  input  wire logic              tx_ok_i,
  input  wire logic              rx_ok_i
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        run;
    logic        cnt_clr;
    logic        err_armed;
    logic        arb_armed;
    logic        err_fresh;
    logic        arb_fresh;
    logic [4:0]  error_segment_code;
    logic        dir;
    logic [1:0]  error_type_code;
    logic [4:0]  arbitration_loss_position;
  } cec_state_s;

  cec_state_s st;
  cec_state_s next_st;

  logic [CEC_CNT_W-1:0] tx_cnt;
  logic [CEC_CNT_W-1:0] rx_cnt;
  logic                 bus_err;
  logic                 wb_req;
  logic                 cap_read;
  logic [7:0]           adr8;

  // Field to segment code
  function automatic logic [4:0] seg_code_of(input cec_field_e f);
    unique case (f)
      CEC_F_IDLE:      seg_code_of = CEC_SEG_INTERMIS;
      CEC_F_SOF:       seg_code_of = CEC_SEG_SOF;
      CEC_F_ID_HI:     seg_code_of = CEC_SEG_ID_28_21;
      CEC_F_ID_MID:    seg_code_of = CEC_SEG_ID_20_18;
      CEC_F_SRTR:      seg_code_of = CEC_SEG_SRTR;
      CEC_F_IDE:       seg_code_of = CEC_SEG_IDE;
      CEC_F_EXT_A:     seg_code_of = CEC_SEG_ID_17_13;
      CEC_F_EXT_B:     seg_code_of = CEC_SEG_ID_12_5;
      CEC_F_EXT_C:     seg_code_of = CEC_SEG_ID_4_0;
      CEC_F_ERTR:      seg_code_of = CEC_SEG_ERTR;
      CEC_F_R1:        seg_code_of = CEC_SEG_R1;
      CEC_F_R0:        seg_code_of = CEC_SEG_R0;
      CEC_F_DLC:       seg_code_of = CEC_SEG_DLC;
      CEC_F_DATA:      seg_code_of = CEC_SEG_DATA;
      CEC_F_CRC:       seg_code_of = CEC_SEG_CRC;
      CEC_F_CRC_DELIM: seg_code_of = CEC_SEG_CRC_DELIM;
      CEC_F_ACK_SLOT:  seg_code_of = CEC_SEG_ACK_SLOT;
      CEC_F_ACK_DELIM: seg_code_of = CEC_SEG_ACK_DELIM;
      CEC_F_EOF:       seg_code_of = CEC_SEG_EOF;
      CEC_F_INTERMIS:  seg_code_of = CEC_SEG_INTERMIS;
      CEC_F_ACT_FLAG:  seg_code_of = CEC_SEG_ACT_FLAG;
      CEC_F_PAS_FLAG:  seg_code_of = CEC_SEG_PAS_FLAG;
      CEC_F_TOL_DOM:   seg_code_of = CEC_SEG_TOL_DOM;
      CEC_F_ERR_DELIM: seg_code_of = CEC_SEG_ERR_DELIM;
      CEC_F_OVL_FLAG:  seg_code_of = CEC_SEG_OVL_FLAG;
      // No own code for the overload delimiter; it shares the error one
      CEC_F_OVL_DELIM: seg_code_of = CEC_SEG_ERR_DELIM;
      default:         seg_code_of = CEC_SEG_INTERMIS;
    endcase
  endfunction

  // Error strobes to type code, bit error taking precedence
  function automatic logic [1:0] error_type_code_of(input logic b, input logic fm, input logic s);
    if (b) begin
      error_type_code_of = CEC_ERROR_TYPE_CODE_BIT;
    end else if (fm) begin
      error_type_code_of = CEC_ERROR_TYPE_CODE_FORM;
    end else if (s) begin
      error_type_code_of = CEC_ERROR_TYPE_CODE_STUFF;
    end else begin
      error_type_code_of = CEC_ERROR_TYPE_CODE_OTHER;
    end
  endfunction

  // Field and bit index to arbitration position
  function automatic logic [4:0] alc_of(input cec_field_e f, input logic [4:0] idx);
    unique case (f)
      CEC_F_ID_HI:  alc_of = CEC_ALC_ID_HI + idx;
      CEC_F_ID_MID: alc_of = CEC_ALC_ID_MID + idx;
      CEC_F_SRTR:   alc_of = CEC_ALC_SRTR;
      CEC_F_IDE:    alc_of = CEC_ALC_IDE;
      CEC_F_EXT_A:  alc_of = CEC_ALC_EXT_A + idx;
      CEC_F_EXT_B:  alc_of = CEC_ALC_EXT_B + idx;
      CEC_F_EXT_C:  alc_of = CEC_ALC_EXT_C + idx;
      CEC_F_ERTR:   alc_of = CEC_ALC_ERTR;
      default:      alc_of = CEC_ALC_ID_HI;
    endcase
  endfunction

  // Packed capture word; reserved bits read zero
  function automatic logic [31:0] capture_word(input cec_state_s s);
    capture_word = '0;
    capture_word[CEC_SEG_LSB +: 5]    = s.error_segment_code;
    capture_word[CEC_DIR_BIT]         = s.dir;
    capture_word[CEC_ERROR_TYPE_CODE_LSB +: 2]   = s.error_type_code;
    capture_word[CEC_ALC_LSB +: 5]    = s.arbitration_loss_position;
    capture_word[CEC_ERR_FRESH_BIT]   = s.err_fresh;
    capture_word[CEC_ARB_FRESH_BIT]   = s.arb_fresh;
  endfunction

  // Zero-extend a counter into a bus word
  function automatic logic [31:0] cnt_word(input logic [CEC_CNT_W-1:0] c);
    cnt_word = {{(32 - CEC_CNT_W){1'b0}}, c};
  endfunction

  assign bus_err  = err_bit_i | err_form_i | err_stuff_i | err_other_i;
  assign wb_req   = wb_cyc_i & wb_stb_i & ~st.ack;
  assign adr8     = 8'(wb_adr_i);
  assign cap_read = wb_req & ~wb_we_i & (adr8 == CEC_OFS_CAPTURE);

  // Transmit errors step by eight, receive errors by one
  cec_fault_counter #(
    .W          (CEC_CNT_W),
    .STEP       (CEC_TX_STEP),
    .RELOAD_EN  (1'b0),
    .RELOAD_LIM (CEC_PASSIVE_LIM),
    .RELOAD_VAL (CEC_RX_RELOAD)
  ) u_tx_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .inc_i   (st.run & bus_err & transmitting_i),
    .dec_i   (st.run & tx_ok_i),
    .clr_i   (st.cnt_clr),
    .count_o (tx_cnt)
  );

  cec_fault_counter #(
    .W          (CEC_CNT_W),
    .STEP       (CEC_RX_STEP),
    .RELOAD_EN  (1'b1),
    .RELOAD_LIM (CEC_PASSIVE_LIM),
    .RELOAD_VAL (CEC_RX_RELOAD)
  ) u_rx_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .inc_i   (st.run & bus_err & ~transmitting_i),
    .dec_i   (st.run & rx_ok_i),
    .clr_i   (st.cnt_clr),
    .count_o (rx_cnt)
  );

  always_comb begin
    next_st         = st;
    next_st.ack     = 1'b0;
    next_st.cnt_clr = 1'b0;

    // Read re-arms both captures; a fresh event below still wins
    if (cap_read) begin
      next_st.err_armed = 1'b1;
      next_st.arb_armed = 1'b1;
      next_st.err_fresh = 1'b0;
      next_st.arb_fresh = 1'b0;
    end

    // Error capture, held through later errors while disarmed
    if (st.run && bus_err && (st.err_armed || cap_read)) begin
      next_st.error_segment_code       = seg_code_of(field_i);
      next_st.dir       = transmitting_i ? CEC_DIR_TX : CEC_DIR_RX;
      next_st.error_type_code      = error_type_code_of(err_bit_i, err_form_i, err_stuff_i);
      next_st.err_fresh = 1'b1;
      next_st.err_armed = 1'b0;
    end

    // Arbitration capture; never touches the counters
    if (st.run && arb_lost_i && (st.arb_armed || cap_read)) begin
      next_st.arbitration_loss_position       = alc_of(field_i, arb_bit_i);
      next_st.arb_fresh = 1'b1;
      next_st.arb_armed = 1'b0;
    end

    if (wb_req) begin
      next_st.ack   = 1'b1;
      next_st.rdata = '0;
      if (wb_we_i) begin
        if (adr8 == CEC_OFS_CTRL && wb_sel_i[0]) begin
          next_st.run     = wb_dat_i[CEC_CTRL_RUN_BIT];
          next_st.cnt_clr = wb_dat_i[CEC_CTRL_CLR_BIT];
          // Start of communication: clear old captures, arm both
          if (wb_dat_i[CEC_CTRL_RUN_BIT] && !st.run) begin
            next_st.error_segment_code       = CEC_SEG_NONE;
            next_st.dir       = CEC_DIR_TX;
            next_st.error_type_code      = CEC_ERROR_TYPE_CODE_BIT;
            next_st.arbitration_loss_position       = CEC_ALC_ID_HI;
            next_st.err_fresh = 1'b0;
            next_st.arb_fresh = 1'b0;
            next_st.err_armed = 1'b1;
            next_st.arb_armed = 1'b1;
          end
        end
      end else begin
        unique case (adr8)
          CEC_OFS_CAPTURE: next_st.rdata = capture_word(st);
          CEC_OFS_RX_CNT:  next_st.rdata = cnt_word(rx_cnt);
          CEC_OFS_TX_CNT:  next_st.rdata = cnt_word(tx_cnt);
          CEC_OFS_CTRL: begin
            next_st.rdata[CEC_CTRL_RUN_BIT] = st.run;
          end
          CEC_OFS_STATUS: begin
            next_st.rdata[CEC_STS_PASSIVE] = (tx_cnt > CEC_PASSIVE_LIM) ||
                                             (rx_cnt > CEC_PASSIVE_LIM);
            next_st.rdata[CEC_STS_BUS_OFF]   = tx_cnt > CEC_BUS_OFF_LIM;
            next_st.rdata[CEC_STS_ERR_ARMED] = st.err_armed;
            next_st.rdata[CEC_STS_ARB_ARMED] = st.arb_armed;
          end
          // Unmapped addresses answer with zero
          default: next_st.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st     <= '0;
      st.run <= CEC_CTRL_RESET[CEC_CTRL_RUN_BIT];
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;

endmodule

// ---- src/cec_pkg.sv ----
/*
  Constants, field layouts and frame-field type for the CAN error and
  arbitration capture block. Assumes a CAN protocol engine beside it that
  reports the current frame field and pulses its error and arbitration events.
*/
// What this block does
// - Each bus error while running advances transmit or receive counter
// - First error after start latched, held until read
// - Reading capture word re-arms error capture
// - Arbitration loss is no error, counters untouched
// - First arbitration loss after start latched until read
// - Reading capture word re-arms arbitration capture
// - Each capture has fresh flag, cleared by read
// - Error byte bits 7-0, arbitration byte 15-8
// - Error fresh flag at bit 16
// - Arbitration fresh flag at bit 17
// - Segment zero means no error recorded
// - Header segment codes 2 to 7
// - Segment codes 8 to 15
// - Error phase codes 17,18,19,22,23
// - Frame tail codes 24 to 28
// - Host can read receive error counter
// - Direction 0 transmit, 1 receive
// - Type 0 bit, 1 form, 2 stuff, 3 other
// - Position 0 first identifier bit to 31
// - Fields hold last captured error, zero before the first
package cec_pkg;

  // Register byte offsets
  localparam logic [7:0] CEC_OFS_CAPTURE = 8'h00;
  localparam logic [7:0] CEC_OFS_RX_CNT  = 8'h04;
  localparam logic [7:0] CEC_OFS_TX_CNT  = 8'h08;
  localparam logic [7:0] CEC_OFS_CTRL    = 8'h0C;
  localparam logic [7:0] CEC_OFS_STATUS  = 8'h10;

  // Capture word layout
  localparam int CEC_SEG_LSB       = 0;
  localparam int CEC_DIR_BIT       = 5;
  localparam int CEC_ERROR_TYPE_CODE_LSB      = 6;
  localparam int CEC_ALC_LSB       = 8;
  localparam int CEC_ERR_FRESH_BIT = 16;
  localparam int CEC_ARB_FRESH_BIT = 17;

  // Control and status bits
  localparam int CEC_CTRL_RUN_BIT   = 0;
  localparam int CEC_CTRL_CLR_BIT   = 1;
  localparam int CEC_STS_PASSIVE    = 0;
  localparam int CEC_STS_BUS_OFF    = 1;
  localparam int CEC_STS_ERR_ARMED  = 2;
  localparam int CEC_STS_ARB_ARMED  = 3;

  localparam logic [31:0] CEC_CTRL_RESET = 32'h0000_0000;

  // Direction codes
  localparam logic CEC_DIR_TX = 1'b0;
  localparam logic CEC_DIR_RX = 1'b1;

  // Error type codes
  localparam logic [1:0] CEC_ERROR_TYPE_CODE_BIT   = 2'h0;
  localparam logic [1:0] CEC_ERROR_TYPE_CODE_FORM  = 2'h1;
  localparam logic [1:0] CEC_ERROR_TYPE_CODE_STUFF = 2'h2;
  localparam logic [1:0] CEC_ERROR_TYPE_CODE_OTHER = 2'h3;

  // Segment codes
  localparam logic [4:0] CEC_SEG_NONE      = 5'h00;
  localparam logic [4:0] CEC_SEG_ID_28_21  = 5'h02;
  localparam logic [4:0] CEC_SEG_SOF       = 5'h03;
  localparam logic [4:0] CEC_SEG_SRTR      = 5'h04;
  localparam logic [4:0] CEC_SEG_IDE       = 5'h05;
  localparam logic [4:0] CEC_SEG_ID_20_18  = 5'h06;
  localparam logic [4:0] CEC_SEG_ID_17_13  = 5'h07;
  localparam logic [4:0] CEC_SEG_CRC       = 5'h08;
  localparam logic [4:0] CEC_SEG_R0        = 5'h09;
  localparam logic [4:0] CEC_SEG_DATA      = 5'h0A;
  localparam logic [4:0] CEC_SEG_DLC       = 5'h0B;
  localparam logic [4:0] CEC_SEG_ERTR      = 5'h0C;
  localparam logic [4:0] CEC_SEG_R1        = 5'h0D;
  localparam logic [4:0] CEC_SEG_ID_4_0    = 5'h0E;
  localparam logic [4:0] CEC_SEG_ID_12_5   = 5'h0F;
  localparam logic [4:0] CEC_SEG_ACT_FLAG  = 5'h11;
  localparam logic [4:0] CEC_SEG_INTERMIS  = 5'h12;
  localparam logic [4:0] CEC_SEG_TOL_DOM   = 5'h13;
  localparam logic [4:0] CEC_SEG_PAS_FLAG  = 5'h16;
  localparam logic [4:0] CEC_SEG_ERR_DELIM = 5'h17;
  localparam logic [4:0] CEC_SEG_CRC_DELIM = 5'h18;
  localparam logic [4:0] CEC_SEG_ACK_SLOT  = 5'h19;
  localparam logic [4:0] CEC_SEG_EOF       = 5'h1A;
  localparam logic [4:0] CEC_SEG_ACK_DELIM = 5'h1B;
  localparam logic [4:0] CEC_SEG_OVL_FLAG  = 5'h1C;

  // Arbitration position bases
  localparam logic [4:0] CEC_ALC_ID_HI   = 5'h00;
  localparam logic [4:0] CEC_ALC_ID_MID  = 5'h08;
  localparam logic [4:0] CEC_ALC_SRTR    = 5'h0B;
  localparam logic [4:0] CEC_ALC_IDE     = 5'h0C;
  localparam logic [4:0] CEC_ALC_EXT_A   = 5'h0D;
  localparam logic [4:0] CEC_ALC_EXT_B   = 5'h12;
  localparam logic [4:0] CEC_ALC_EXT_C   = 5'h1A;
  localparam logic [4:0] CEC_ALC_ERTR    = 5'h1F;

  // Fault confinement figures
  localparam int          CEC_CNT_W       = 9;
  localparam logic [8:0]  CEC_TX_STEP     = 9'h008;
  localparam logic [8:0]  CEC_RX_STEP     = 9'h001;
  localparam logic [8:0]  CEC_PASSIVE_LIM = 9'h07F;
  localparam logic [8:0]  CEC_BUS_OFF_LIM = 9'h0FF;
  localparam logic [8:0]  CEC_RX_RELOAD   = 9'h078;

  // Frame field reported by the protocol engine
  typedef enum logic [4:0] {
    CEC_F_IDLE, CEC_F_SOF, CEC_F_ID_HI, CEC_F_ID_MID, CEC_F_SRTR, CEC_F_IDE,
    CEC_F_EXT_A, CEC_F_EXT_B, CEC_F_EXT_C, CEC_F_ERTR, CEC_F_R1, CEC_F_R0,
    CEC_F_DLC, CEC_F_DATA, CEC_F_CRC, CEC_F_CRC_DELIM, CEC_F_ACK_SLOT,
    CEC_F_ACK_DELIM, CEC_F_EOF, CEC_F_INTERMIS, CEC_F_ACT_FLAG, CEC_F_PAS_FLAG,
    CEC_F_TOL_DOM, CEC_F_ERR_DELIM, CEC_F_OVL_FLAG, CEC_F_OVL_DELIM
  } cec_field_e;

endpackage

// ---- src/cec_fault_counter.sv ----
/*
  One fault-confinement error counter: adds a step per error, subtracts one
  per successful frame, optionally reloads from above a limit.
  Assumes increment and decrement strobes are single-cycle pulses.
*/
module cec_fault_counter
  import cec_pkg::*;
#(
  parameter int             W          = CEC_CNT_W,
  parameter logic [W-1:0]   STEP       = 1,
  parameter bit             RELOAD_EN  = 1'b0,
  parameter logic [W-1:0]   RELOAD_LIM = CEC_PASSIVE_LIM,
  parameter logic [W-1:0]   RELOAD_VAL = CEC_RX_RELOAD
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         inc_i,
  input  wire logic         dec_i,
  input  wire logic         clr_i,
  output logic [W-1:0]      count_o
);

  typedef struct packed {
    logic [W-1:0] count;
  } cec_cnt_s;

  cec_cnt_s st;
  cec_cnt_s next_st;

  always_comb begin
    logic [W:0] sum;
    sum     = {1'b0, st.count} + {1'b0, STEP};
    next_st = st;
    if (clr_i) begin
      next_st.count = '0;
    end else if (inc_i) begin
      // Saturate rather than wrap; a wrap would look like recovery
      next_st.count = sum[W] ? '1 : sum[W-1:0];
    end else if (dec_i) begin
      if (RELOAD_EN && st.count > RELOAD_LIM) begin
        next_st.count = RELOAD_VAL;
      end else if (st.count != '0) begin
        next_st.count = st.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.count;

endmodule

// ---- sim/cec_capture_asserts.sv ----
/*
  Checker for cec_capture: bus timing and capture/fresh-flag behaviour.
  Assumes it is bound to cec_capture and sees only its ports.
*/
module cec_capture_asserts
  import cec_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADR_W-1:0]  wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              err_bit_i,
  input wire logic              err_form_i,
  input wire logic              err_stuff_i,
  input wire logic              err_other_i,
  input wire logic              arb_lost_i
);
  logic       take, rd_cap, wr_ctl, go, ce, ca;
  logic       run_q, ea, ef, aa, af, seen, rp;
  logic [7:0] le;

  assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_cap = take && !wb_we_i && wb_adr_i[7:0] == CEC_OFS_CAPTURE;
  assign wr_ctl = take && wb_we_i && wb_adr_i[7:0] == CEC_OFS_CTRL && wb_sel_i[0];
  assign go     = wr_ctl && wb_dat_i[0] && !run_q;
  // A read in the same cycle re-arms in time for the event
  assign ce     = run_q && (ea || rd_cap) &&
                  (err_bit_i || err_form_i || err_stuff_i || err_other_i);
  assign ca     = run_q && (aa || rd_cap) && arb_lost_i;

  // Shadow of arm/fresh state; a capture beats a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {run_q, ea, ef, aa, af, seen, rp} <= 7'h00;
      le <= 8'h00;
    end else begin
      rp <= rd_cap;
      if (rp && wb_ack_o) le <= wb_dat_o[7:0];
      if (wr_ctl) run_q <= wb_dat_i[0];
      if (go) begin
        {ea, ef, aa, af, seen} <= 5'h14;
      end else begin
        if (ce) {ea, ef, seen} <= 3'h3;
        else if (rd_cap) {ea, ef} <= 2'h2;
        if (ca) {aa, af} <= 2'h1;
        else if (rd_cap) {aa, af} <= 2'h2;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cap_rd;
    s_take ##0 (!wb_we_i && wb_adr_i[7:0] == CEC_OFS_CAPTURE);
  endsequence

  a_ack_latency: assert property (s_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (!take |=> !wb_ack_o)
    else $error("ack without request");
  a_err_fresh: assert property (s_cap_rd |=> wb_dat_o[16] == $past(ef))
    else $error("error fresh flag wrong");
  a_arb_fresh: assert property (s_cap_rd |=> wb_dat_o[17] == $past(af))
    else $error("arbitration fresh flag wrong");
  a_fresh_seg: assert property (s_cap_rd ##0 ef |=> wb_dat_o[4:0] != CEC_SEG_NONE)
    else $error("fresh error with empty segment");
  a_empty_zero: assert property (s_cap_rd ##0 !seen |=> wb_dat_o[7:0] == 8'h00)
    else $error("error byte not zero before any error");
  a_err_held: assert property (s_cap_rd ##0 (seen && !ef) |=> wb_dat_o[7:0] == le)
    else $error("error byte changed without new capture");
endmodule

bind cec_capture cec_capture_asserts #(.ADR_W(ADR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .err_bit_i(err_bit_i),
  .err_form_i(err_form_i), .err_stuff_i(err_stuff_i), .err_other_i(err_other_i),
  .arb_lost_i(arb_lost_i));

// ---- sim/cec_bus_node.sv ----
/*
  Model of the bus side: frame field, direction and one-cycle event pulses.
  Assumes tasks are called right after a rising clock edge.
*/
module cec_bus_node
  import cec_pkg::*;
(
  input  wire logic  clk_i,
  output cec_field_e field_o,
  output logic       tx_o,
  output logic [3:0] err_o,
  output logic       arb_o,
  output logic [4:0] abit_o,
  output logic       tok_o,
  output logic       rok_o
);
  initial begin
    field_o = CEC_F_IDLE;
    {tx_o, err_o, arb_o, abit_o, tok_o, rok_o} = 13'h0000;
  end

  // Ev: [3:0] bit/form/stuff/other, [4] arb loss, [5] tx ok, [6] rx ok
  // Two cycles per event so no pulse line is driven twice in one step
  task automatic pulse(input cec_field_e f, input logic tx, input logic [7:0] ev,
                       input logic [4:0] b);
    field_o <= f;
    tx_o <= tx;
    abit_o <= b;
    {rok_o, tok_o, arb_o, err_o} <= ev[6:0];
    @(posedge clk_i);
    {rok_o, tok_o, arb_o, err_o} <= 7'h00;
    abit_o <= ~b;
    @(posedge clk_i);
  endtask
endmodule

// ---- sim/cec_capture_tb.sv ----
/*
  Self-checking bench for cec_capture: Wishbone reads checked from a queue.
  Assumes the checker is bound in and cec_bus_node drives the bus side.
*/
module cec_capture_tb
  import cec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  wire  [31:0] rdat;
  wire         ack, txing, arb, tok, rok;
  wire  [3:0]  err;
  wire  [4:0]  abit;
  cec_field_e  fld;
  int          n_mismatch = 0, total_checks = 0;
  logic [63:0] exp_q[$];
  logic [7:0]  eb;
  logic [4:0]  ab, b;
  logic        ef, af, d;
  logic [1:0]  t;
  logic [8:0]  rx_c, tx_c;
  logic [4:0]  seg_t[26] = '{5'h12, 5'h03, 5'h02, 5'h06, 5'h04, 5'h05, 5'h07, 5'h0F,
    5'h0E, 5'h0C, 5'h0D, 5'h09, 5'h0B, 5'h0A, 5'h08, 5'h18, 5'h19, 5'h1B, 5'h1A,
    5'h12, 5'h11, 5'h16, 5'h13, 5'h17, 5'h1C, 5'h17};
  logic [4:0]  ab_t[8] = '{CEC_ALC_ID_HI, CEC_ALC_ID_MID, CEC_ALC_SRTR, CEC_ALC_IDE,
    CEC_ALC_EXT_A, CEC_ALC_EXT_B, CEC_ALC_EXT_C, CEC_ALC_ERTR};
  logic [3:0]  aw[8] = '{4'h8, 4'h3, 4'h1, 4'h1, 4'h5, 4'h8, 4'h5, 4'h1};

  always #12.5 clk = ~clk;

  cec_capture #(.ADR_W(8)) DUT (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .field_i(fld), .transmitting_i(txing), .err_bit_i(err[0]), .err_form_i(err[1]),
    .err_stuff_i(err[2]), .err_other_i(err[3]), .arb_lost_i(arb), .arb_bit_i(abit),
    .tx_ok_i(tok), .rx_ok_i(rok));

  cec_bus_node NODE (
    .clk_i(clk), .field_o(fld), .tx_o(txing), .err_o(err), .arb_o(arb),
    .abit_o(abit), .tok_o(tok), .rok_o(rok));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: read %h expected %h", $time, seen, exp);
    end
  endtask

  // Watcher: each ack takes the oldest note
  always @(posedge clk) begin
    if (ack === 1'h1) begin
      if (exp_q.size() == 0) check(rdat, 32'hDEAD_0000);
      else check(rdat & exp_q[0][63:32], exp_q[0][31:0]);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt, e, m);
    int n;
    exp_q.push_back({m, e & m});
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= dt; sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (ack !== 1'h1) begin
      n_mismatch++;
      report_and_stop();
    end else begin
      cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
      @(posedge clk);
    end
  endtask

  // Reserved bits are masked off
  task automatic rdcap();
    bus(1'h0, CEC_OFS_CAPTURE, 32'h0, {14'h0, af, ef, 3'h0, ab, eb}, 32'h0003_1FFF);
    ef = 1'h0;
    af = 1'h0;
  endtask

  task automatic cnts();
    bus(1'h0, CEC_OFS_RX_CNT, 32'h0, {23'h0, rx_c}, 32'hFFFF_FFFF);
    bus(1'h0, CEC_OFS_TX_CNT, 32'h0, {23'h0, tx_c}, 32'hFFFF_FFFF);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    void'($urandom(37));
    {eb, ab, ef, af, rx_c, tx_c} = 33'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdcap(); // Nothing yet
    bus(1'h1, CEC_OFS_CTRL, 32'h0000_0001, 32'h0, 32'h0);
    // Every field, random direction and type
    for (int i = 0; i < 26; i++) begin
      d = 1'($urandom);
      t = 2'($urandom);
      NODE.pulse(cec_field_e'(i), !d, 8'h01 << t, 5'h00);
      eb = {t, d, seg_t[i]};
      ef = 1'h1;
      if (d) rx_c = rx_c + 9'h001;
      else tx_c = tx_c + 9'h008;
      rdcap();
    end
    cnts();
    // Back to back errors: first one is kept
    NODE.pulse(CEC_F_CRC, 1'h0, 8'h02, 5'h00);
    NODE.pulse(CEC_F_EOF, 1'h1, 8'h08, 5'h00);
    eb = {2'h1, 1'h1, CEC_SEG_CRC};
    ef = 1'h1;
    rx_c = rx_c + 9'h001;
    tx_c = tx_c + 9'h008;
    rdcap();
    rdcap(); // Same fields, flag clear
    for (int i = 0; i < 8; i++) begin
      b = 5'($urandom % aw[i]);
      NODE.pulse(cec_field_e'(i + 2), 1'h1, 8'h10, b);
      ab = ab_t[i] + b;
      af = 1'h1;
      rdcap();
    end
    NODE.pulse(CEC_F_ID_HI, 1'h1, 8'h10, 5'h03);
    NODE.pulse(CEC_F_IDE, 1'h1, 8'h10, 5'h00);
    ab = 5'h03;
    af = 1'h1;
    rdcap();
    cnts(); // No count on arbitration loss
    NODE.pulse(CEC_F_EOF, 1'h1, 8'h20, 5'h00);
    NODE.pulse(CEC_F_EOF, 1'h0, 8'h40, 5'h00);
    tx_c = tx_c - 9'h001;
    rx_c = rx_c - 9'h001;
    bus(1'h1, CEC_OFS_RX_CNT, 32'h0000_01FF, 32'h0, 32'h0);
    cnts(); // Read-only counter kept
    bus(1'h0, 8'h14, 32'h0, 32'h0, 32'hFFFF_FFFF);
    // Read and error in one cycle: read sees old word, error still caught
    fork
      NODE.pulse(CEC_F_DATA, 1'h0, 8'h04, 5'h00);
      rdcap();
    join
    eb = {2'h2, 1'h1, CEC_SEG_DATA};
    ef = 1'h1;
    rx_c = rx_c + 9'h001;
    rdcap();
    // Stopped: errors are not captured
    bus(1'h1, CEC_OFS_CTRL, 32'h0000_0000, 32'h0, 32'h0);
    NODE.pulse(CEC_F_DATA, 1'h0, 8'h04, 5'h00);
    rdcap();
    cnts(); // Stopped: no counting
    bus(1'h0, CEC_OFS_STATUS, 32'h0, {28'h0, 2'h3, tx_c > CEC_BUS_OFF_LIM,
        (tx_c > CEC_PASSIVE_LIM) || (rx_c > CEC_PASSIVE_LIM)}, 32'h0000_000F);
    // Clear bit empties both counters
    bus(1'h1, CEC_OFS_CTRL, 32'h0000_0002, 32'h0, 32'h0);
    {rx_c, tx_c} = 18'h0;
    cnts();
    // Restart drops old captures and re-arms
    bus(1'h1, CEC_OFS_CTRL, 32'h0000_0001, 32'h0, 32'h0);
    bus(1'h0, CEC_OFS_CTRL, 32'h0, 32'h0000_0001, 32'hFFFF_FFFF);
    {eb, ab} = 13'h0;
    rdcap();
    // Reset in mid-run wipes a fresh capture and the counters
    NODE.pulse(CEC_F_SOF, 1'h1, 8'h01, 5'h00);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdcap();
    cnts();
    report_and_stop();
  end
endmodule
